// file: verilog/pfr_core.sv
`timescale 1ns/1ns
// Function
// - Codes 011..110 restart 3..6 times, then stay off until cleared.
// - Code 111 retries forever until off command, bias loss or other fault.
// - Delay field value n means two to the n delay units.
// - Delay is the grace time while running or the gap between retries.
// - Delay unit length comes from the output voltage fault time unit setting.
// - Retry starts are spaced by delay count times time unit.
// - Hold 16-bit turn-off delay value.
// - Hold 16-bit turn-off fall time value.
// - Warn when output misses 12.5 percent within the turn-off limit.
// - Hold output over-power limit; warn when output power exceeds it.
// - Hold input over-power limit; warn when input power exceeds it.
// - Summary bit 6 set whenever output is not powered.
// - Bits 5, 4, 3 flag output overvoltage, overcurrent, input undervoltage.
// - Bit 2 flags temperature; bit 1 flags communication, memory, logic.
// - Bit 0 flags any fault or warning not covered by bits 7..1.
// - Word bit 15 flags any output voltage fault or warning.
// - Bit 14 flags output current or power; bit 13 flags input.
// - Bit 12 flags maker-specific; bit 11 flags power-good negated.
// - Bit 9 set when any other-status bit is set.
// - Response field selects ignore, delay-retry, disable-retry or latch off.
// - Latched fault clears by clear command, reset, off-then-on, or bias loss.
module pfr_core (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [7:0] i_cmd,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  input wire logic [15:0] i_time_unit_us,
  input wire logic i_ton_fault,
  input wire logic i_restart_ok,
  input wire logic i_on_cmd,
  input wire logic i_bias_ok,
  input wire logic i_other_shutdown,
  input wire logic i_clear_faults,
  input wire logic i_vout_below_eighth,
  input wire logic [15:0] i_pout,
  input wire logic [15:0] i_pin,
  input wire logic i_powering,
  input wire logic i_vout_ov_fault,
  input wire logic i_vout_other_flag,
  input wire logic i_iout_oc_fault,
  input wire logic i_iout_other_flag,
  input wire logic i_vin_uv_fault,
  input wire logic i_input_other_flag,
  input wire logic i_temp_flag,
  input wire logic i_cml_flag,
  input wire logic i_mfr_flag,
  input wire logic i_pgood_present,
  input wire logic i_pgood,
  input wire logic [7:0] i_other_status,
  output logic o_output_enable,
  output logic o_restart_pulse,
  output logic o_toff_warn,
  output logic o_pout_warn,
  output logic o_pin_warn,
  output logic [15:0] o_turn_off_delay,
  output logic [15:0] o_turn_off_fall_time
);
  import pfr_pkg::*;

  logic [15:0] turn_off_timeout_warn_limit;
  logic [15:0] output_overpower_warn_limit;
  logic [15:0] input_overpower_warn_limit;
  logic [7:0] turn_on_timeout_fault_response;
  logic [7:0] summary_status_byte;
  logic [15:0] summary_status_word;
  pfr_state_t state;
  logic [7:0] us_cnt;
  logic us_tick;
  logic [15:0] unit_us_cnt;
  logic [7:0] unit_pre;
  logic unit_tick;
  logic [7:0] unit_cnt;
  logic [7:0] delay_units;
  logic [2:0] retry_cnt;
  logic [2:0] retry_limit;
  logic [1:0] resp;
  logic on_prev;
  logic off_on_clear;
  logic ms_tick;
  logic [9:0] ms_us_cnt;
  logic [15:0] toff_ms;
  logic toff_active;

  assign resp = turn_on_timeout_fault_response[RESP_HI:RESP_LO];
  assign retry_limit = turn_on_timeout_fault_response[RETRY_HI:RETRY_LO];
  // Two to the field value delay units
  assign delay_units = 8'h01 << turn_on_timeout_fault_response[DELAY_HI:DELAY_LO];
  assign off_on_clear = i_on_cmd & ~on_prev;

  // Register writes
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_turn_off_delay <= WORD_RESET;
      o_turn_off_fall_time <= WORD_RESET;
      turn_off_timeout_warn_limit <= WORD_RESET;
      output_overpower_warn_limit <= WORD_RESET;
      input_overpower_warn_limit <= WORD_RESET;
      turn_on_timeout_fault_response <= TON_RESP_RESET;
    end else if (i_wr) begin
      unique case (i_cmd)
        CMD_TURN_OFF_DELAY: o_turn_off_delay <= i_wdata;
        CMD_TURN_OFF_FALL: o_turn_off_fall_time <= i_wdata;
        CMD_TOFF_WARN_LIMIT: turn_off_timeout_warn_limit <= i_wdata;
        CMD_POUT_WARN_LIMIT: output_overpower_warn_limit <= i_wdata;
        CMD_PIN_WARN_LIMIT: input_overpower_warn_limit <= i_wdata;
        CMD_TON_RESPONSE: turn_on_timeout_fault_response <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux, registered
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_rdata <= WORD_RESET;
    end else begin
      unique case (i_cmd)
        CMD_TURN_OFF_DELAY: o_rdata <= o_turn_off_delay;
        CMD_TURN_OFF_FALL: o_rdata <= o_turn_off_fall_time;
        CMD_TOFF_WARN_LIMIT: o_rdata <= turn_off_timeout_warn_limit;
        CMD_POUT_WARN_LIMIT: o_rdata <= output_overpower_warn_limit;
        CMD_PIN_WARN_LIMIT: o_rdata <= input_overpower_warn_limit;
        CMD_TON_RESPONSE: o_rdata <= {8'h00, turn_on_timeout_fault_response};
        CMD_STATUS_BYTE: o_rdata <= {8'h00, summary_status_byte};
        CMD_STATUS_WORD: o_rdata <= summary_status_word;
        default: o_rdata <= WORD_RESET;
      endcase
    end
  end

  // Summary byte from the live sources
  always_comb begin
    summary_status_byte = 8'h00;
    summary_status_byte[SB_OFF] = ~i_powering;
    summary_status_byte[SB_VOUT_OV] = i_vout_ov_fault;
    summary_status_byte[SB_IOUT_OC] = i_iout_oc_fault;
    summary_status_byte[SB_VIN_UV] = i_vin_uv_fault;
    summary_status_byte[SB_TEMP] = i_temp_flag;
    summary_status_byte[SB_CML] = i_cml_flag;
    summary_status_byte[SB_OTHER_NA] = i_vout_other_flag | i_iout_other_flag |
      i_input_other_flag | i_mfr_flag | (|i_other_status) | o_toff_warn |
      o_pout_warn | o_pin_warn | (state == PFR_LATCHED) |
      (i_pgood_present & ~i_pgood);
  end

  // Summary word, low byte shared with the byte
  always_comb begin
    summary_status_word = {8'h00, summary_status_byte};
    summary_status_word[SW_VOUT] = i_vout_ov_fault | i_vout_other_flag |
      o_toff_warn | (state == PFR_LATCHED);
    summary_status_word[SW_IOUT_POUT] = i_iout_oc_fault | i_iout_other_flag |
      o_pout_warn;
    summary_status_word[SW_INPUT] = i_vin_uv_fault | i_input_other_flag |
      o_pin_warn;
    summary_status_word[SW_MFR] = i_mfr_flag;
    summary_status_word[SW_PGOOD_N] = i_pgood_present & ~i_pgood;
    summary_status_word[SW_OTHER] = |i_other_status;
  end

  // Microsecond and millisecond enables
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      us_cnt <= 8'h00;
      us_tick <= 1'b0;
      ms_us_cnt <= 10'h000;
      ms_tick <= 1'b0;
    end else begin
      us_tick <= (us_cnt == 8'(US_CYCLES - 1));
      us_cnt <= (us_cnt == 8'(US_CYCLES - 1)) ? 8'h00 : us_cnt + 8'h01;
      ms_tick <= us_tick && (ms_us_cnt == 10'(MS_US - 1));
      // Millisecond phase restarts while the turn-off watch is idle
      if (o_output_enable || i_vout_below_eighth) begin
        ms_us_cnt <= 10'h000;
      end else if (us_tick) begin
        ms_us_cnt <= (ms_us_cnt == 10'(MS_US - 1)) ? 10'h000 : ms_us_cnt + 10'h001;
      end
    end
  end

  // Delay unit enable; own prescaler so the first unit after a fault is whole
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      unit_pre <= 8'h00;
      unit_us_cnt <= WORD_RESET;
      unit_tick <= 1'b0;
    end else begin
      unit_tick <= 1'b0;
      if (state == PFR_RUN) begin
        unit_pre <= 8'h00;
        unit_us_cnt <= WORD_RESET;
      end else if (unit_pre != 8'(US_CYCLES - 1)) begin
        unit_pre <= unit_pre + 8'h01;
      end else begin
        unit_pre <= 8'h00;
        if (unit_us_cnt + 16'h0001 >= i_time_unit_us) begin
          unit_us_cnt <= WORD_RESET;
          unit_tick <= 1'b1;
        end else begin
          unit_us_cnt <= unit_us_cnt + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) on_prev <= 1'b0;
    else on_prev <= i_on_cmd;
  end

  // Retry sequencer
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state <= PFR_RUN;
      unit_cnt <= 8'h00;
      retry_cnt <= 3'h0;
      o_output_enable <= 1'b0;
      o_restart_pulse <= 1'b0;
    end else begin
      o_restart_pulse <= 1'b0;
      if (unit_tick) unit_cnt <= unit_cnt + 8'h01;
      if (i_clear_faults || !i_bias_ok || off_on_clear) begin
        state <= PFR_RUN;
        retry_cnt <= 3'h0;
        unit_cnt <= 8'h00;
        o_output_enable <= i_on_cmd & i_bias_ok;
      end else if (state != PFR_LATCHED && (!i_on_cmd || i_other_shutdown)) begin
        state <= PFR_LATCHED;
        o_output_enable <= 1'b0;
      end else begin
        unique case (state)
          PFR_RUN: begin
            o_output_enable <= i_on_cmd;
            unit_cnt <= 8'h00;
            if (i_ton_fault) begin
              unique case (resp)
                RESP_IGNORE: ;
                RESP_DELAY_RETRY: state <= PFR_GRACE;
                RESP_DISABLE_RETRY: begin
                  o_output_enable <= 1'b0;
                  state <= (retry_limit == 3'h0) ? PFR_LATCHED : PFR_WAIT;
                end
                RESP_LATCH_OFF: begin
                  o_output_enable <= 1'b0;
                  state <= PFR_LATCHED;
                end
              endcase
            end
          end
          PFR_GRACE: begin
            if (!i_ton_fault) begin
              state <= PFR_RUN;
            end else if (unit_cnt >= delay_units) begin
              o_output_enable <= 1'b0;
              unit_cnt <= 8'h00;
              state <= (retry_limit == 3'h0) ? PFR_LATCHED : PFR_WAIT;
            end
          end
          PFR_WAIT: begin
            if (unit_cnt >= delay_units) begin
              unit_cnt <= 8'h00;
              o_output_enable <= 1'b1;
              o_restart_pulse <= 1'b1;
              if (retry_limit != RETRY_FOREVER) retry_cnt <= retry_cnt + 3'h1;
              state <= PFR_TRY;
            end
          end
          PFR_TRY: begin
            if (i_restart_ok) begin
              state <= PFR_RUN;
              retry_cnt <= 3'h0;
            end else if (i_ton_fault) begin
              o_output_enable <= 1'b0;
              if (retry_limit != RETRY_FOREVER && retry_cnt >= retry_limit) begin
                state <= PFR_LATCHED;
              end else begin
                state <= PFR_WAIT;
              end
            end
          end
          PFR_LATCHED: o_output_enable <= 1'b0;
        endcase
      end
    end
  end

  // Turn-off timeout watch, in milliseconds
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      toff_active <= 1'b0;
      toff_ms <= WORD_RESET;
      o_toff_warn <= 1'b0;
    end else begin
      if (i_clear_faults) o_toff_warn <= 1'b0;
      if (o_output_enable || i_vout_below_eighth) begin
        toff_active <= 1'b0;
        toff_ms <= WORD_RESET;
      end else begin
        toff_active <= 1'b1;
        if (toff_active && ms_tick) toff_ms <= toff_ms + 16'h0001;
        if (toff_active && toff_ms >= turn_off_timeout_warn_limit) o_toff_warn <= 1'b1;
      end
    end
  end

  // Over-power warnings
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_pout_warn <= 1'b0;
      o_pin_warn <= 1'b0;
    end else begin
      o_pout_warn <= i_pout > output_overpower_warn_limit;
      o_pin_warn <= i_pin > input_overpower_warn_limit;
    end
  end

  // Checks
  sequence wait_done_s;
    state == PFR_WAIT && unit_cnt >= delay_units && !i_clear_faults && i_bias_ok &&
      !off_on_clear && i_on_cmd && !i_other_shutdown;
  endsequence
  restart_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    wait_done_s |=> o_restart_pulse && o_output_enable && state == PFR_TRY)
    else $error("restart not issued after delay");
  retry_limit_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    state == PFR_TRY && !i_restart_ok && i_ton_fault && retry_limit != RETRY_FOREVER &&
    retry_cnt >= retry_limit && !i_clear_faults && i_bias_ok && !off_on_clear &&
    i_on_cmd && !i_other_shutdown |=> state == PFR_LATCHED)
    else $error("retry limit not honoured");
  forever_retry_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    retry_limit == RETRY_FOREVER && state == PFR_WAIT |=> retry_cnt == $past(retry_cnt))
    else $error("unlimited retry counted");
  latched_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    state == PFR_LATCHED ##1 state == PFR_LATCHED |-> !o_output_enable)
    else $error("output on while latched");
  clear_fault_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clear_faults |=> state == PFR_RUN && retry_cnt == 3'h0)
    else $error("clear faults ignored");
  off_bit_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_cmd == CMD_STATUS_BYTE |=> o_rdata[SB_OFF] == !$past(i_powering))
    else $error("off bit wrong");
  low_byte_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_cmd == CMD_STATUS_WORD |=> o_rdata[7:0] == $past(summary_status_byte))
    else $error("word low byte differs");
  pout_warn_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_pout > output_overpower_warn_limit && $stable(output_overpower_warn_limit)
    |=> o_pout_warn)
    else $error("output power warning missed");
  pin_warn_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $rose(o_pin_warn) |-> $past(i_pin) > $past(input_overpower_warn_limit))
    else $error("input power warning spurious");
  other_bit_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (|i_other_status) |-> summary_status_word[SW_OTHER] && summary_status_byte[SB_OTHER_NA])
    else $error("other status bit missing");
endmodule : pfr_core

// file: verilog/pfr_pkg.sv
package pfr_pkg;
  // Command codes of the registers held here
  localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
  localparam logic [7:0] CMD_TURN_OFF_FALL = 8'h65;
  localparam logic [7:0] CMD_TOFF_WARN_LIMIT = 8'h66;
  localparam logic [7:0] CMD_POUT_WARN_LIMIT = 8'h6a;
  localparam logic [7:0] CMD_PIN_WARN_LIMIT = 8'h6b;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_TON_RESPONSE = 8'h63;

  // Response field layout
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAY_RETRY = 2'h1;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH_OFF = 2'h3;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Reset values
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] TON_RESP_RESET = 8'h00;

  // Summary bit positions
  localparam int SB_OFF = 6;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_IOUT_OC = 4;
  localparam int SB_VIN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SB_OTHER_NA = 0;
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT_POUT = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_MFR = 12;
  localparam int SW_PGOOD_N = 11;
  localparam int SW_OTHER = 9;

  // Time unit prescaler: one microsecond at 25 MHz
  localparam int CLK_MHZ = 25;
  localparam int US_CYCLES = CLK_MHZ;
  // Microseconds in one millisecond
  localparam int MS_US = 1000;

  typedef enum logic [4:0] {
    PFR_RUN = 5'b00001,
    PFR_GRACE = 5'b00010,
    PFR_WAIT = 5'b00100,
    PFR_TRY = 5'b01000,
    PFR_LATCHED = 5'b10000
  } pfr_state_t;
endpackage : pfr_pkg

// file: test/pfr_host.sv
`timescale 1ns/1ns
// Management bus host: drives command, write strobe and data; reads after one registered cycle
module pfr_host (
  input wire logic i_clk_sys,
  input wire logic [15:0] i_rdata,
  output logic [7:0] o_cmd,
  output logic o_wr,
  output logic [15:0] o_wdata
);
  // Idle state at time zero
  initial begin
    o_cmd = 8'h00;
    o_wr = 1'b0;
    o_wdata = 16'h0000;
  end

  // One-cycle write; the data lines then show the inverse of the last word
  task automatic write(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge i_clk_sys);
    o_cmd <= cmd;
    o_wr <= 1'b1;
    o_wdata <= data;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    o_wdata <= ~data;
  endtask : write

  // Read answer is registered one cycle after the command is presented
  task automatic read(input logic [7:0] cmd, output logic [15:0] data);
    @(posedge i_clk_sys);
    o_cmd <= cmd;
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    data = i_rdata;
  endtask : read
endmodule : pfr_host

// file: test/pfr_core_test.sv
`timescale 1ns/1ns
module pfr_core_test;
  import pfr_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] cmd;
  logic wr;
  logic [15:0] wdata, rdata, tdel, tfall, v, w;
  logic [15:0] pout = 16'h0000, pin = 16'h0000;
  logic [11:0] flg = 12'h000;
  logic ton = 1'b0, on_c = 1'b1, clr = 1'b0, low = 1'b0;
  logic oth = 1'b0, bias = 1'b1;
  logic [15:0] tu = 16'h0001;
  logic en, pls, twarn, pwarn, iwarn;
  logic [7:0] cmds [8] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h6a, 8'h6b, 8'h78, 8'h79};
  int pos [12] = '{5, 4, 3, 2, 1, 12, 15, 11, 9, 6, 14, 13};
  logic [11:0] none_above = 12'hde0;
  int error_cnt = 0, checks = 0, cyc = 0, n, g;

  // System clock, 40 ns period
  always #20 i_clk_sys = ~i_clk_sys;

  pfr_host host_u (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_cmd(cmd), .o_wr(wr),
    .o_wdata(wdata));

  pfr_core dut_u (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cmd(cmd), .i_wr(wr),
    .i_wdata(wdata), .o_rdata(rdata), .i_time_unit_us(tu), .i_ton_fault(ton),
    .i_restart_ok(1'b0), .i_on_cmd(on_c), .i_bias_ok(bias), .i_other_shutdown(oth),
    .i_clear_faults(clr), .i_vout_below_eighth(low), .i_pout(pout), .i_pin(pin),
    .i_powering(~flg[9]), .i_vout_ov_fault(flg[0]), .i_vout_other_flag(flg[6]),
    .i_iout_oc_fault(flg[1]), .i_iout_other_flag(flg[10]), .i_vin_uv_fault(flg[2]),
    .i_input_other_flag(flg[11]), .i_temp_flag(flg[3]), .i_cml_flag(flg[4]),
    .i_mfr_flag(flg[5]), .i_pgood_present(1'b1), .i_pgood(~flg[7]),
    .i_other_status(flg[8] ? 8'h04 : 8'h00), .o_output_enable(en),
    .o_restart_pulse(pls), .o_toff_warn(twarn), .o_pout_warn(pwarn), .o_pin_warn(iwarn),
    .o_turn_off_delay(tdel), .o_turn_off_fall_time(tfall));

  task automatic end_of_test;
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Counts restart pulses over a window and the gap between the first two
  task automatic pulses(input int len, output int cnt, output int gap);
    int t, last;
    cnt = 0;
    gap = 0;
    last = 0;
    for (t = 0; t < len; t++) begin
      @(posedge i_clk_sys);
      if (pls === 1'b1) begin
        if (cnt == 1) gap = t - last;
        last = t;
        cnt++;
      end
    end
  endtask : pulses

  // Programs a response, raises the turn-on fault and watches the retries
  task automatic retry(input logic [7:0] resp, input int len);
    host_u.write(CMD_TON_RESPONSE, {8'h00, resp});
    @(posedge i_clk_sys);
    ton <= 1'b1;
    pulses(len, n, g);
    ton <= 1'b0;
  endtask : retry

  task automatic clear;
    @(posedge i_clk_sys);
    clr <= 1'b1;
    @(posedge i_clk_sys);
    clr <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask : clear

  // Hang guard
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    // Reset values, then write and read back each stored register
    for (int k = 0; k < 8; k++) begin
      host_u.read(cmds[k], v);
      chk("reset value", v, 16'h0000);
    end
    for (int k = 0; k < 6; k++) begin
      w = (k == 0) ? 16'h00a5 : {cmds[k], 8'ha5};
      host_u.write(cmds[k], w);
      host_u.read(cmds[k], v);
      chk("readback", v, w);
    end
    chk("turn off delay", tdel, 16'h64a5);
    chk("turn off fall", tfall, 16'h65a5);
    host_u.write(CMD_STATUS_WORD, 16'hffff);
    host_u.read(CMD_STATUS_WORD, v);
    chk("status read only", v, 16'h0000);
    host_u.write(8'h70, 16'h1234);
    host_u.read(8'h70, v);
    chk("unmapped", v, 16'h0000);
    host_u.write(CMD_TON_RESPONSE, 16'h0000);
    // Each status source alone
    for (int k = 0; k < 12; k++) begin
      @(posedge i_clk_sys);
      flg <= 12'h001 << k;
      host_u.read(CMD_STATUS_WORD, v);
      chk("status bit", {15'h0000, v[pos[k]]}, 16'h0001);
      chk("none of above", {15'h0000, v[0]}, {15'h0000, none_above[k]});
      host_u.read(CMD_STATUS_BYTE, w);
      chk("byte equals word", w, {8'h00, v[7:0]});
    end
    flg <= 12'h000;
    // Over-power warnings above the limit only
    host_u.write(CMD_POUT_WARN_LIMIT, 16'h0064);
    host_u.write(CMD_PIN_WARN_LIMIT, 16'h0064);
    pout <= 16'h0065;
    pin <= 16'h0064;
    repeat (3) @(posedge i_clk_sys);
    chk("pout warn", {15'h0000, pwarn}, 16'h0001);
    chk("pin warn", {15'h0000, iwarn}, 16'h0000);
    pout <= 16'h0064;
    pin <= 16'h0065;
    repeat (3) @(posedge i_clk_sys);
    chk("pout warn", {15'h0000, pwarn}, 16'h0000);
    chk("pin warn", {15'h0000, iwarn}, 16'h0001);
    // Counted retries, codes 3 to 6, delay one unit
    for (int r = 3; r < 7; r++) begin
      retry({2'h2, r[2:0], 3'h0}, 300);
      chk("retry count", n[15:0], r[15:0]);
      chk("latched off", {15'h0000, en}, 16'h0000);
      clear();
      chk("cleared on", {15'h0000, en}, 16'h0001);
    end
    retry(8'h80, 200);
    chk("no retry", n[15:0], 16'h0000);
    clear();
    // Endless retry with four units between starts, stopped by the off command
    retry({2'h2, 3'h7, 3'h2}, 450);
    chk("endless count", n[15:0], 16'h0004);
    chk("retry gap", {15'h0000, g >= 100 && g <= 103}, 16'h0001);
    on_c <= 1'b0;
    pulses(300, n, g);
    chk("stopped by off", n[15:0], 16'h0000);
    on_c <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    chk("off then on", {15'h0000, en}, 16'h0001);
    // Another fault shuts down and latches; bias loss clears it
    oth <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    oth <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    chk("other shutdown", {15'h0000, en}, 16'h0000);
    bias <= 1'b0;
    @(posedge i_clk_sys);
    bias <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk("bias loss clears", {15'h0000, en}, 16'h0001);
    retry({2'h3, 3'h7, 3'h0}, 200);
    chk("latch off", n[15:0], 16'h0000);
    chk("latch off en", {15'h0000, en}, 16'h0000);
    clear();
    retry({2'h0, 3'h7, 3'h0}, 200);
    chk("ignore", n[15:0], 16'h0000);
    chk("ignore en", {15'h0000, en}, 16'h0001);
    // Grace period of one two-microsecond unit, then the retry setting
    tu <= 16'h0002;
    host_u.write(CMD_TON_RESPONSE, 16'h0040);
    @(posedge i_clk_sys);
    ton <= 1'b1;
    repeat (30) @(posedge i_clk_sys);
    chk("grace running", {15'h0000, en}, 16'h0001);
    repeat (40) @(posedge i_clk_sys);
    chk("grace ended", {15'h0000, en}, 16'h0000);
    ton <= 1'b0;
    clear();
    // Output never falls below an eighth within one millisecond
    host_u.write(CMD_TOFF_WARN_LIMIT, 16'h0001);
    @(posedge i_clk_sys);
    on_c <= 1'b0;
    for (n = 0; n < 60000 && twarn !== 1'b1; n++) @(posedge i_clk_sys);
    chk("toff warn", {15'h0000, twarn}, 16'h0001);
    chk("toff warn time", {15'h0000, n >= 24900 && n <= 25100}, 16'h0001);
    low <= 1'b1;
    clear();
    chk("toff warn cleared", {15'h0000, twarn}, 16'h0000);
    end_of_test();
  end
endmodule : pfr_core_test
